// File: hw/ipd_pkg.sv
// Operation
// [RL1] Assert settled output when droop magnitude is within window under chosen condition.
// [RL2] Settled output is not latched; it follows droop in and out of window.
// [RL3] Network-command and pulse-bus variants default the window to 25600 pulses.
// [RL4] Analog/pulse-input variant defaults the window to 400 pulses.
// [RL5] Unit select 0 compares in command pulses, 1 in encoder pulses.
// [RL6] Condition 0: settled depends only on droop within window.
// [RL7] Condition 1: also requires command pulse output finished.
// [RL8] Condition 2, network variant only: also requires start signal released.
// [RL9] Host should pick condition 1 when trace control keeps droop near zero.
// [RL10] Host should shrink the window if settled stays on in slow motion.
// [RL11] Unit conversion uses gear ratio on command side, inverse on feedback side.
// [RL12] Droop is signed command minus feedback; window tests its magnitude.
package ipd_pkg;
   localparam int          IPD_POS_W        = 32;
   localparam int          IPD_GEAR_W       = 32;
   localparam int          IPD_WIN_W        = 24;
   localparam int          IPD_VARIANT_G    = 0;
   localparam int          IPD_VARIANT_B    = 1;
   localparam int          IPD_VARIANT_A    = 2;
   localparam int          IPD_WIN_RST_GB   = 25600;
   localparam int          IPD_WIN_RST_A    = 400;
   localparam logic        IPD_UNIT_CMD     = 1'h0;
   localparam logic        IPD_UNIT_ENC     = 1'h1;
   localparam logic [1:0]  IPD_COND_WINDOW  = 2'h0;
   localparam logic [1:0]  IPD_COND_CMD_END = 2'h1;
   localparam logic [1:0]  IPD_COND_START   = 2'h2;
   localparam logic [1:0]  IPD_UNIT_RST     = 2'h0;
   localparam logic [1:0]  IPD_COND_RST     = 2'h0;
endpackage : ipd_pkg

// File: hw/ipd_in_position_detector.sv
`timescale 1ns/1ps
module ipd_in_position_detector
   import ipd_pkg::*;
#(
   parameter int VARIANT = IPD_VARIANT_G,
   parameter int POS_W   = IPD_POS_W,
   parameter int GEAR_W  = IPD_GEAR_W,
   parameter int WIN_W   = IPD_WIN_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Configuration, taken at an edge where cfg_load is high.
   input  wire logic              cfg_load,
   input  wire logic [WIN_W-1:0]  settle_window_size,
   input  wire logic              window_unit_select,
   input  wire logic [1:0]        settle_condition_select,
   // Electronic gear, read every cycle.
   input  wire logic [GEAR_W-1:0] gear_numerator,
   input  wire logic [GEAR_W-1:0] gear_denominator,
   // Positions and command state from the host controller, sampled every edge.
   input  wire logic [POS_W-1:0]  cmd_position,
   input  wire logic [POS_W-1:0]  fb_position,
   input  wire logic              cmd_output_done,
   input  wire logic              start_signal,
   // Status, every bit straight from a register.
   output logic                   position_settled_flag,
   output logic [POS_W-1:0]       droop_magnitude,
   output logic [WIN_W-1:0]       active_window_size,
   output logic                   active_window_unit,
   output logic [1:0]             active_settle_condition
);

   localparam int PROD_W = POS_W + GEAR_W;

   // Parameter checks run at elaboration, so a bad build stops before time zero.
   if (VARIANT < IPD_VARIANT_G || VARIANT > IPD_VARIANT_A) begin : g_bad_variant
      $error("ipd_in_position_detector: unknown VARIANT");
   end
   // The window register must hold the larger reset value, and the plain
   // compare widens the window to the droop width, so it may not be wider.
   if (WIN_W < 16 || WIN_W > POS_W) begin : g_bad_win_w
      $error("ipd_in_position_detector: WIN_W must hold the window reset value");
   end
   // A droop needs a sign bit next to its magnitude.
   if (POS_W < 2 || GEAR_W < 1) begin : g_bad_width
      $error("ipd_in_position_detector: width too small");
   end

   // Window reset value differs per variant: the analog variant starts with a
   // much smaller window than the other two.
   localparam logic [WIN_W-1:0] WIN_RST = (VARIANT == IPD_VARIANT_A) ?
      WIN_W'(IPD_WIN_RST_A) :  // RL4
      WIN_W'(IPD_WIN_RST_GB);  // RL3

   // Configuration held between load strobes.
   logic [WIN_W-1:0]  win_ff;
   logic              unit_ff;
   logic [1:0]        cond_ff;

   // Pipeline stages.
   logic [POS_W-1:0]  droop_ff;
   logic [POS_W-1:0]  droop_mag_ff;
   logic              settled_ff;

   // Next values.
   logic [POS_W-1:0]  nxt_droop;
   logic [POS_W-1:0]  nxt_mag;
   logic              nxt_settled;
   logic              nxt_unit;
   logic [1:0]        nxt_cond;

   // Window compare in both units.
   logic [PROD_W-1:0] enc_prod;
   logic [PROD_W-1:0] cmd_prod;
   logic              cmd_in_window;
   logic              enc_in_window;
   logic              in_window;

   // Droop, magnitude and settled flag are three register stages, so positions
   // sampled at one edge show on the flag two edges later. The status copies
   // lag the live settings by one edge, which lines them up with the flag that
   // they produced. After reset every stage holds zero droop, so with the reset
   // window the flag rises at the first edge after release; the host should
   // load a window before it trusts the flag.

   // A value of 3 is not defined and falls back to the window-only condition.
   // Condition 2 needs a start signal, which only the network variant has;
   // elsewhere it falls back to 1, the nearest condition that still waits
   // for the end of command output.
   always_comb begin
      nxt_cond = settle_condition_select;
      if (settle_condition_select > IPD_COND_START)
         nxt_cond = IPD_COND_WINDOW;
      else if (settle_condition_select == IPD_COND_START && VARIANT != IPD_VARIANT_G)
         nxt_cond = IPD_COND_CMD_END;
   end

   // The pulse-bus variant has no unit field, so it always compares command pulses.
   always_comb begin
      nxt_unit = window_unit_select;
      if (VARIANT == IPD_VARIANT_B)
         nxt_unit = IPD_UNIT_CMD;
   end

   // Each field is taken at a load strobe and holds until the next one, so the
   // host may change the setting pins freely between strobes.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         win_ff <= WIN_RST;  // RL3 RL4
      else if (cfg_load)
         win_ff <= settle_window_size;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         unit_ff <= IPD_UNIT_RST[0];
      else if (cfg_load)
         unit_ff <= nxt_unit;  // RL5
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         cond_ff <= IPD_COND_RST;
      else if (cfg_load)
         cond_ff <= nxt_cond;  // RL6 RL7 RL8
   end

   // Stage one: signed droop, command minus feedback, in command pulses.
   // Registering it first keeps the subtract and the negate out of one path.
   assign nxt_droop = cmd_position - fb_position;  // RL12

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         droop_ff <= '0;
      else
         droop_ff <= nxt_droop;
   end

   // Stage two: magnitude, so droop of either sign meets the same window. The
   // most negative droop has no positive twin and wraps onto itself; the
   // positions never drift that far apart in service.
   always_comb begin
      nxt_mag = droop_ff[POS_W-1] ? (~droop_ff + POS_W'(1)) : droop_ff;  // RL12
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         droop_mag_ff <= '0;
      else
         droop_mag_ff <= nxt_mag;
   end

   // For the encoder unit the droop would be scaled by gear_numerator over
   // gear_denominator. Multiplying both sides out instead, |d| * numerator
   // against window * denominator, keeps the compare exact with no divider.
   // PROD_W holds the full product, so no bits are lost. A zero denominator
   // lets only zero droop count as settled; the host must not load one.
   assign enc_prod = PROD_W'(droop_mag_ff) * PROD_W'(gear_numerator);  // RL11
   assign cmd_prod = PROD_W'(win_ff) * PROD_W'(gear_denominator);      // RL11

   // Both compares are formed every cycle and the unit only picks one, so a
   // unit change shows at the next edge without a gap in the flag.
   assign cmd_in_window = (droop_mag_ff <= POS_W'(win_ff));
   assign enc_in_window = (enc_prod <= cmd_prod);

   always_comb begin
      if (unit_ff == IPD_UNIT_ENC)  // RL5
         in_window = enc_in_window;
      else
         in_window = cmd_in_window;
   end

   // Stage three: the flag is recomputed every cycle from the window and the
   // chosen condition; nothing holds it, so overshoot drops it again.
   // Condition 2 never reaches cond_ff on the other variants.
   always_comb begin
      case (cond_ff)
         IPD_COND_WINDOW:  nxt_settled = in_window;                     // RL6
         IPD_COND_CMD_END: nxt_settled = in_window && cmd_output_done;  // RL7
         IPD_COND_START:   nxt_settled = in_window && cmd_output_done
                                         && !start_signal;              // RL8
         default:          nxt_settled = in_window;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         settled_ff <= 1'h0;
      else
         settled_ff <= nxt_settled;  // RL1 RL2
   end

   // Status copies, one register each, so that every output port comes
   // straight from a flip-flop and lines up with the flag.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         droop_magnitude <= '0;
      else
         droop_magnitude <= droop_mag_ff;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         active_window_size <= WIN_RST;
      else
         active_window_size <= win_ff;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         active_window_unit <= IPD_UNIT_RST[0];
      else
         active_window_unit <= unit_ff;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         active_settle_condition <= IPD_COND_RST;
      else
         active_settle_condition <= cond_ff;
   end

   // The flag port is the stage-three register itself, with no logic after it.
   assign position_settled_flag = settled_ff;

endmodule : ipd_in_position_detector

// File: verification/ipd_checker.sv
`timescale 1ns/1ps
module ipd_checker
   import ipd_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        cfg_load,
   input wire logic [23:0] settle_window_size,
   input wire logic        window_unit_select,
   input wire logic [1:0]  settle_condition_select,
   input wire logic [31:0] gear_numerator,
   input wire logic [31:0] gear_denominator,
   input wire logic [31:0] cmd_position,
   input wire logic [31:0] fb_position,
   input wire logic        cmd_output_done,
   input wire logic        start_signal,
   input wire logic        position_settled_flag,
   input wire logic [31:0] droop_magnitude,
   input wire logic [23:0] active_window_size,
   input wire logic        active_window_unit,
   input wire logic [1:0]  active_settle_condition
);
   logic [31:0] dif;
   assign dif = cmd_position - fb_position;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // The flag checks skip the first edge after reset, where the flag still shows its reset value.
   droop_abs_a: assert property (
      droop_magnitude == ($past(dif[31], 3) ? -$past(dif, 3) : $past(dif, 3))) else $error("bad droop");
   win_only_a: assert property ($past(rstn) && active_settle_condition == 0 && !active_window_unit |->
      position_settled_flag == (droop_magnitude <= active_window_size)) else $error("bad flag");
   cmd_end_a: assert property ($past(rstn) && active_settle_condition == 1 && !active_window_unit |->
      position_settled_flag == (droop_magnitude <= active_window_size && $past(cmd_output_done)))
      else $error("bad flag, cmd end");
   start_off_a: assert property ($past(rstn) && active_settle_condition == 2 && !active_window_unit |->
      position_settled_flag == (droop_magnitude <= active_window_size && $past(cmd_output_done)
      && !$past(start_signal))) else $error("bad flag, start");
   enc_unit_a: assert property ($past(rstn) && active_window_unit && active_settle_condition == 0 |->
      position_settled_flag == (64'(droop_magnitude) * $past(gear_numerator)
      <= 64'(active_window_size) * $past(gear_denominator))) else $error("bad flag, encoder unit");
   win_cap_a: assert property (cfg_load |-> ##2 active_window_size == $past(settle_window_size, 2))
      else $error("window not captured");
   unit_cap_a: assert property (cfg_load |-> ##2 active_window_unit == $past(window_unit_select, 2))
      else $error("unit not captured");
   cond_cap_a: assert property (cfg_load |-> ##2 active_settle_condition ==
      ($past(settle_condition_select, 2) == 3 ? 2'h0 : $past(settle_condition_select, 2)))
      else $error("condition not captured");
   cover property ($fell(position_settled_flag));
   cover property (active_settle_condition == 2 && position_settled_flag);
   cover property (active_window_unit && position_settled_flag);
endmodule : ipd_checker

// File: verification/ipd_host_model.sv
`timescale 1ns/1ps
module ipd_host_model
   import ipd_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic [31:0] target,
   input wire logic        go,
   output logic [31:0]     cmd_position,
   output logic            cmd_output_done,
   output logic            start_signal
);
   logic [31:0] cmd_ff;
   // Commands ramp by eight pulses a cycle, so a long move keeps command output busy for a while.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) cmd_ff <= 32'h0;
      else if (cmd_ff + 32'h8 < target) cmd_ff <= cmd_ff + 32'h8;
      else cmd_ff <= target;
   end
   assign cmd_position = cmd_ff;
   assign cmd_output_done = (cmd_ff == target);
   assign start_signal = go;
endmodule : ipd_host_model

// File: verification/ipd_in_position_detector_tb.sv
`timescale 1ns/1ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t got %0h expected %0h", $time, (a), (b)); end end
module ipd_in_position_detector_tb
   import ipd_pkg::*;
();
   logic sys_clk = 1'b0, rstn = 1'b0, cfg_load = 1'b0, go = 1'b0, window_unit_select = 1'b0;
   logic [1:0]  settle_condition_select = 2'h0;
   logic [23:0] settle_window_size = 24'h0;
   logic [31:0] target = 32'h0, fb_position = 32'h0, gear_numerator = 32'h3, gear_denominator = 32'h2;
   logic [31:0] cmd_position, droop_magnitude;
   logic cmd_output_done, start_signal, position_settled_flag, active_window_unit;
   logic [23:0] active_window_size;
   logic [1:0]  active_settle_condition;
   int err_total = 0;
   int samples_checked = 0;
   always #12.5 sys_clk = ~sys_clk;
   ipd_host_model host (.*);
   ipd_in_position_detector DUT (.*);
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic cfg(input logic [23:0] w, input logic u, input logic [1:0] c);
      @(posedge sys_clk);
      settle_window_size <= w;
      window_unit_select <= u;
      settle_condition_select <= c;
      cfg_load <= 1'b1;
      @(posedge sys_clk);
      cfg_load <= 1'b0;
   endtask : cfg
   // Waits are sized from the three-cycle flag latency and the host ramp rate.
   task automatic drive(input logic [31:0] t, input logic g, input logic [31:0] f, input int n);
      @(posedge sys_clk);
      target <= t;
      go <= g;
      fb_position <= f;
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : drive
   initial begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      `CK(active_window_size, 24'(IPD_WIN_RST_GB))
      `CK(active_window_unit, IPD_UNIT_CMD)
      `CK(active_settle_condition, IPD_COND_RST)
      $display("reset test done");
      cfg(24'hA, 1'b0, 2'h3);
      drive(32'h64, 1'b0, 32'h5A, 30);
      `CK(active_settle_condition, IPD_COND_WINDOW)
      `CK(position_settled_flag, 1'b1)
      `CK(droop_magnitude, 32'hA)
      drive(32'h64, 1'b0, 32'h59, 6);
      `CK(position_settled_flag, 1'b0)
      drive(32'h64, 1'b0, 32'h6F, 6);
      `CK(droop_magnitude, 32'hB)
      drive(32'h64, 1'b0, 32'h6E, 6);
      `CK(position_settled_flag, 1'b1)
      $display("window test done");
      cfg(24'hFFFFFF, 1'b0, 2'h1);
      drive(32'h3E8, 1'b0, 32'h3E8, 8);
      `CK(position_settled_flag, 1'b0)
      drive(32'h3E8, 1'b0, 32'h3E8, 120);
      `CK(position_settled_flag, 1'b1)
      cfg(24'h4, 1'b0, 2'h0);
      drive(32'h7D0, 1'b0, 32'h3E8, 8);
      `CK(position_settled_flag, 1'b0)
      $display("command end test done");
      cfg(24'hA, 1'b0, 2'h2);
      drive(32'h7D0, 1'b1, 32'h7D0, 300);
      `CK(position_settled_flag, 1'b0)
      drive(32'h7D0, 1'b0, 32'h7D0, 6);
      `CK(position_settled_flag, 1'b1)
      $display("start test done");
      cfg(24'hA, 1'b1, 2'h0);
      drive(32'h7D0, 1'b0, 32'h7CA, 6);
      `CK(position_settled_flag, 1'b1)
      drive(32'h7D0, 1'b0, 32'h7C9, 6);
      `CK(position_settled_flag, 1'b0)
      $display("encoder unit test done");
      stop_test();
   end
   initial begin
      #50us;
      err_total++;
      stop_test();
   end
endmodule : ipd_in_position_detector_tb
bind ipd_in_position_detector ipd_checker chk (.*);
